// File: verilog/sbg_consts.svh
`ifndef SBG_CONSTS_SVH
`define SBG_CONSTS_SVH
// Register byte offsets
`define SBG_A_SBY 12'h000
`define SBG_A_UNL 12'h004
`define SBG_A_STAT 12'h008
`define SBG_A_VEC 12'h00C
`define SBG_A_BLK 12'h010
`define SBG_NGRP 5
// Standby control fields
`define SBG_B_HALT 0
`define SBG_B_STOP 1
`define SBG_B_FOSC 2
`define SBG_FOSC_RST 1'b1
// Unlock codes, upper nibble
`define SBG_UNL_1ST 4'h5
`define SBG_UNL_2ND 4'hA
// Start vectors
`define SBG_VEC_NORM 16'h0002
`define SBG_VEC_BRK 16'h0004
// Exception levels
`define SBG_LVL_NONE 2'h0
`define SBG_LVL_MASK 2'h1
`define SBG_LVL_NMI 2'h2
`define SBG_LVL_EMU 2'h3
// Pulse counts
`define SBG_RC_CNT 128
`define SBG_FOSC_CNT 4096
`define SBG_XTL_CNT 8192
// Wake pins inside the request vector
`define SBG_WAKE_BASE 8
`define SBG_WAKE_NUM 4
// Timing, ns
`define SBG_CLK_NS 10
`define SBG_XTH_NS 2000
`define SBG_XTL_NS 20000
`endif

// File: verilog/sbg_pkg.sv
`default_nettype none
package sbg_pkg;
   typedef enum logic [3:0] {
      ST_RUN = 4'b0001,
      ST_HALT = 4'b0010,
      ST_STOP = 4'b0100,
      ST_WAKE = 4'b1000
   } sbg_pwr_type;
   typedef enum logic [2:0] {
      UL_IDLE = 3'b001,
      UL_GOT1 = 3'b010,
      UL_ARMED = 3'b100
   } sbg_unl_type;
   typedef struct packed {
      logic nmi_req;
      logic wdt_req;
      logic master_irq_enable;
      logic [1:0] exception_level_field;
   } sbg_core_type;
   typedef struct packed {
      logic slow_osc_en;
      logic fast_osc_en;
      logic slow_supply;
      logic fast_supply;
      logic slow_from_xtal;
   } sbg_clk_type;
endpackage : sbg_pkg
`default_nettype wire

// File: verilog/sbg_pulse_count.sv
`timescale 1ns/1ps
`default_nettype none
module sbg_pulse_count #(
   parameter int TARGET = 128
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic start,
   input wire logic osc_pin,
   output logic done
);
   localparam int W = $clog2(TARGET + 1);
   if (TARGET < 1) begin : g_bad
      $error("TARGET must be at least one");
   end
   logic s1_ff, s2_ff, s3_ff, act_ff, done_ff;
   logic [W-1:0] cnt_ff;
   // Two-stage synchroniser, then edge detect
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
         s3_ff <= 1'b0;
      end else begin
         s1_ff <= osc_pin;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= '0;
         act_ff <= 1'b0;
         done_ff <= 1'b0;
      end else if (start) begin
         cnt_ff <= '0;
         act_ff <= 1'b1;
         done_ff <= 1'b0;
      end else if (act_ff && s2_ff && !s3_ff) begin
         cnt_ff <= cnt_ff + 1'b1;
         if (cnt_ff == W'(TARGET - 1)) begin
            act_ff <= 1'b0;
            done_ff <= 1'b1;
         end
      end
   end
   assign done = done_ff;
endmodule : sbg_pulse_count
`default_nettype wire

// File: verilog/sbg_standby.sv
// Contract
// - Ordinary resets start fetching from the vector at 0002H/0003H.
// - Break reset uses 0004H/0005H, unless level was 02H or higher.
// - Writing the halt bit enters HALT; CPU idles, peripherals run.
// - NMI, watchdog or enabled request clears halt bit at next edge.
// - At most two instructions run between HALT release and vectoring.
// - STOP needs unlock armed by writes 5nH then 0AnH.
// - Entering STOP disarms the unlock.
// - STOP halts both oscillators, the CPU and all peripherals.
// - Only NMI or enabled wake-pin request releases STOP.
// - Slow-clock wake restarts slow osc; fast osc only if it ran.
// - Slow-clock STOP releases after 128 RC cycles, clocks resupplied.
// - After crystal start time and 8192 pulses, switch slow clock.
// - Fast-clock wake restarts both; release after start time and 4096.
// - Fast-clock wake resupplies slow clock after 128 RC cycles.
// - STOP follows the setting write; two instructions before vector.
// - NMI wakes only with flag; level 3 no vector, else vectors.
// - Maskable wakes with enable and flag; vectors if MASTER_IRQ_ENABLE, level 0/1.
// - Level codes 0 none, 1 maskable, 2 non-maskable, 3 emulator.
// - Block disable bits reset to 0; 1 resets and gates the block.
// - Disabled block ignores writes and reads initial values.
// - Groups 0,6 timers; 2 serial; 4 display, battery, ADC; 7 PWM.
// - HALT or STOP refused while an enabled request is pending.
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "sbg_consts.svh"
module sbg_standby #(
   parameter int IRQ_NUM = 64,
   parameter int XTH_NS = `SBG_XTH_NS,
   parameter int XTL_NS = `SBG_XTL_NS
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Processor core
   input wire sbg_pkg::sbg_core_type core,
   input wire logic [IRQ_NUM-1:0] irq_req,
   input wire logic [IRQ_NUM-1:0] irq_en,
   input wire logic cpu_on_fast,
   input wire logic break_reset,
   input wire logic [1:0] break_exception_level_field,
   output logic [15:0] start_vector,
   output logic cpu_hold,
   output logic resume,
   output logic resume_vector,
   // Oscillators
   input wire logic rc_osc_pin,
   input wire logic fast_osc_pin,
   input wire logic slow_xtal_pin,
   input wire logic fast_osc_running,
   output var sbg_pkg::sbg_clk_type clk_ctrl,
   output logic slow_switch_event,
   // Block gating
   output logic [8*`SBG_NGRP-1:0] blk_disable
);
   localparam int XTH_CYC = (XTH_NS + `SBG_CLK_NS - 1) / `SBG_CLK_NS;
   localparam int XTL_CYC = (XTL_NS + `SBG_CLK_NS - 1) / `SBG_CLK_NS;
   if (IRQ_NUM < `SBG_WAKE_BASE + `SBG_WAKE_NUM) begin : g_bad
      $error("IRQ_NUM too small for wake pins");
   end
   if (XTH_CYC < 1 || XTL_CYC < 1 || XTL_CYC > 16777215) begin : g_bad_t
      $error("start times out of range");
   end

   function automatic logic mapped(input logic [11:0] a);
      mapped = (a == `SBG_A_SBY) || (a == `SBG_A_UNL) ||
               (a == `SBG_A_STAT) || (a == `SBG_A_VEC) ||
               (a >= `SBG_A_BLK && a < `SBG_A_BLK + 12'h014 &&
                a[1:0] == 2'h0);
   endfunction : mapped

   // Vectoring decision on wake
   function automatic logic go_vector(input sbg_pkg::sbg_core_type c);
      if (c.nmi_req || c.wdt_req) begin
         go_vector = c.exception_level_field != `SBG_LVL_EMU;
      end else begin
         go_vector = c.master_irq_enable && c.exception_level_field < `SBG_LVL_NMI;
      end
   endfunction : go_vector

   sbg_pkg::sbg_pwr_type st_ff;
   sbg_pkg::sbg_unl_type ul_ff;
   logic [31:0] prdata_ff;
   logic [7:0] blk_ff [`SBG_NGRP];
   logic [15:0] vec_ff;
   logic boot_ff, fosc_sw_ff, fast_case_ff, fast_was_ff;
   logic resume_ff, resvec_ff, wakevec_ff, sw_evt_ff;
   logic slow_osc_ff, fast_osc_ff, slow_sup_ff, fast_sup_ff, xtal_ff;
   logic fr1_ff, fr2_ff;
   logic xtl_busy_ff, fst_busy_ff;
   logic [23:0] xtl_tmr_ff, fst_tmr_ff;
   logic rc_done, fst_done, xtl_done;
   logic wr, wr_sby, wr_unl, pending, wake_halt, wake_stop;
   logic halt_go, stop_go, stop_wake, fst_rel, rc_rel, xtl_go, xtl_sw;
   logic [3:0] nib;

   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped(paddr);
   assign wr = psel && penable && pwrite && mapped(paddr);
   assign wr_sby = wr && paddr == `SBG_A_SBY;
   assign wr_unl = wr && paddr == `SBG_A_UNL;
   assign nib = pwdata[7:4];

   assign pending = |(irq_req & irq_en);
   assign wake_halt = core.nmi_req || core.wdt_req || pending;
   assign wake_stop = core.nmi_req ||
      |(irq_req[`SBG_WAKE_BASE +: `SBG_WAKE_NUM] &
        irq_en[`SBG_WAKE_BASE +: `SBG_WAKE_NUM]);

   // Entry requests; STOP wins when both bits are written with the unlock armed
   assign stop_go = wr_sby && pwdata[`SBG_B_STOP] && !pending &&
      st_ff == sbg_pkg::ST_RUN && ul_ff == sbg_pkg::UL_ARMED;
   assign halt_go = wr_sby && pwdata[`SBG_B_HALT] && !pending &&
      st_ff == sbg_pkg::ST_RUN && !stop_go;
   assign stop_wake = st_ff == sbg_pkg::ST_STOP && wake_stop;
   assign fst_rel = st_ff == sbg_pkg::ST_WAKE && fast_case_ff &&
      fst_busy_ff && fst_tmr_ff == 24'h000000 && fst_done;
   assign rc_rel = rc_done && !slow_sup_ff &&
      st_ff != sbg_pkg::ST_STOP;
   assign xtl_go = rc_rel || boot_ff;
   assign xtl_sw = xtl_busy_ff && xtl_tmr_ff == 24'h000000 &&
      xtl_done;

   // Power state machine
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= sbg_pkg::ST_RUN;
      end else begin
         case (st_ff)
            sbg_pkg::ST_RUN: begin
               if (stop_go) begin
                  st_ff <= sbg_pkg::ST_STOP;
               end else if (halt_go) begin
                  st_ff <= sbg_pkg::ST_HALT;
               end
            end
            sbg_pkg::ST_HALT: begin
               if (wake_halt) begin
                  st_ff <= sbg_pkg::ST_RUN;
               end
            end
            sbg_pkg::ST_STOP: begin
               if (wake_stop) begin
                  st_ff <= sbg_pkg::ST_WAKE;
               end
            end
            sbg_pkg::ST_WAKE: begin
               if (fast_case_ff ? fst_rel : rc_rel) begin
                  st_ff <= sbg_pkg::ST_RUN;
               end
            end
            default: st_ff <= sbg_pkg::ST_RUN;
         endcase
      end
   end

   // Stop unlock sequence
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ul_ff <= sbg_pkg::UL_IDLE;
      end else if (stop_go) begin
         ul_ff <= sbg_pkg::UL_IDLE;
      end else if (wr_unl) begin
         case (ul_ff)
            sbg_pkg::UL_GOT1: begin
               if (nib == `SBG_UNL_2ND) begin
                  ul_ff <= sbg_pkg::UL_ARMED;
               end else if (nib == `SBG_UNL_1ST) begin
                  ul_ff <= sbg_pkg::UL_GOT1;
               end else begin
                  ul_ff <= sbg_pkg::UL_IDLE;
               end
            end
            default: begin
               ul_ff <= (nib == `SBG_UNL_1ST) ? sbg_pkg::UL_GOT1 :
                  sbg_pkg::UL_IDLE;
            end
         endcase
      end
   end

   // Resume pulses towards the core
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         resume_ff <= 1'b0;
         resvec_ff <= 1'b0;
         wakevec_ff <= 1'b0;
      end else begin
         if (stop_wake) begin
            wakevec_ff <= go_vector(core);
         end
         if (st_ff == sbg_pkg::ST_HALT && wake_halt) begin
            resume_ff <= 1'b1;
            resvec_ff <= go_vector(core);
         end else if (st_ff == sbg_pkg::ST_WAKE &&
                      (fast_case_ff ? fst_rel : rc_rel)) begin
            resume_ff <= 1'b1;
            resvec_ff <= wakevec_ff;
         end else begin
            resume_ff <= 1'b0;
            resvec_ff <= 1'b0;
         end
      end
   end

   // Start vector, caught after reset release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         boot_ff <= 1'b1;
         vec_ff <= `SBG_VEC_NORM;
      end else begin
         boot_ff <= 1'b0;
         if (boot_ff) begin
            vec_ff <= (break_reset && break_exception_level_field < `SBG_LVL_NMI) ?
               `SBG_VEC_BRK : `SBG_VEC_NORM;
         end
      end
   end

   // Fast oscillator status synchroniser and STOP context
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fr1_ff <= 1'b0;
         fr2_ff <= 1'b0;
         fast_case_ff <= 1'b0;
         fast_was_ff <= 1'b0;
      end else begin
         fr1_ff <= fast_osc_running;
         fr2_ff <= fr1_ff;
         if (stop_go) begin
            fast_case_ff <= cpu_on_fast;
            fast_was_ff <= fr2_ff && fast_osc_ff;
         end
      end
   end

   // Oscillator enables and clock supply
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fosc_sw_ff <= `SBG_FOSC_RST;
         slow_osc_ff <= 1'b1;
         fast_osc_ff <= `SBG_FOSC_RST;
         slow_sup_ff <= 1'b1;
         fast_sup_ff <= `SBG_FOSC_RST;
      end else if (stop_go) begin
         slow_osc_ff <= 1'b0;
         fast_osc_ff <= 1'b0;
         slow_sup_ff <= 1'b0;
         fast_sup_ff <= 1'b0;
      end else begin
         if (wr_sby && st_ff == sbg_pkg::ST_RUN) begin
            fosc_sw_ff <= pwdata[`SBG_B_FOSC];
            fast_osc_ff <= pwdata[`SBG_B_FOSC];
            fast_sup_ff <= pwdata[`SBG_B_FOSC];
         end
         if (stop_wake) begin
            slow_osc_ff <= 1'b1;
            fast_osc_ff <= fast_case_ff || fast_was_ff;
         end
         if (rc_rel) begin
            slow_sup_ff <= 1'b1;
            if (!fast_case_ff && st_ff == sbg_pkg::ST_WAKE) begin
               fast_sup_ff <= fast_was_ff;
            end
         end
         if (fst_rel) begin
            fast_sup_ff <= 1'b1;
         end
      end
   end

   // Fast start time then oscillator pulse count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fst_busy_ff <= 1'b0;
         fst_tmr_ff <= 24'h000000;
      end else if (stop_wake && fast_case_ff) begin
         fst_busy_ff <= 1'b1;
         fst_tmr_ff <= 24'(XTH_CYC);
      end else if (fst_rel || stop_go) begin
         fst_busy_ff <= 1'b0;
      end else if (fst_busy_ff && fst_tmr_ff != 24'h000000) begin
         fst_tmr_ff <= fst_tmr_ff - 24'h000001;
      end
   end

   // Slow crystal start time, pulse count and switch-over
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xtl_busy_ff <= 1'b0;
         xtl_tmr_ff <= 24'h000000;
         xtal_ff <= 1'b0;
         sw_evt_ff <= 1'b0;
      end else begin
         sw_evt_ff <= 1'b0;
         if (stop_go) begin
            xtl_busy_ff <= 1'b0;
            xtal_ff <= 1'b0;
         end else if (xtl_go) begin
            xtl_busy_ff <= 1'b1;
            xtl_tmr_ff <= 24'(XTL_CYC);
         end else if (xtl_sw) begin
            xtl_busy_ff <= 1'b0;
            xtal_ff <= 1'b1;
            sw_evt_ff <= 1'b1;
         end else if (xtl_busy_ff && xtl_tmr_ff != 24'h000000) begin
            xtl_tmr_ff <= xtl_tmr_ff - 24'h000001;
         end
      end
   end

   sbg_pulse_count #(.TARGET(`SBG_RC_CNT)) u_rc_cnt (
      .pclk(pclk),
      .presetn(presetn),
      .start(stop_wake),
      .osc_pin(rc_osc_pin),
      .done(rc_done)
   );
   sbg_pulse_count #(.TARGET(`SBG_FOSC_CNT)) u_fst_cnt (
      .pclk(pclk),
      .presetn(presetn),
      .start(fst_busy_ff && fst_tmr_ff == 24'h000001),
      .osc_pin(fast_osc_pin),
      .done(fst_done)
   );
   sbg_pulse_count #(.TARGET(`SBG_XTL_CNT)) u_xtl_cnt (
      .pclk(pclk),
      .presetn(presetn),
      .start(xtl_busy_ff && xtl_tmr_ff == 24'h000001),
      .osc_pin(slow_xtal_pin),
      .done(xtl_done)
   );

   // Block disable groups 0, 2, 4, 6, 7
   for (genvar g = 0; g < `SBG_NGRP; g++) begin : g_blk
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            blk_ff[g] <= 8'h00;
         end else if (wr && paddr == `SBG_A_BLK + 12'(4 * g)) begin
            blk_ff[g] <= pwdata[7:0];
         end
      end
      assign blk_disable[8*g +: 8] = blk_ff[g];
   end

   // Read data, taken in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h00000000;
      end else if (psel && !penable) begin
         prdata_ff <= 32'h00000000;
         if (paddr == `SBG_A_SBY) begin
            prdata_ff[`SBG_B_HALT] <= st_ff == sbg_pkg::ST_HALT;
            prdata_ff[`SBG_B_STOP] <= st_ff == sbg_pkg::ST_STOP;
            prdata_ff[`SBG_B_FOSC] <= fosc_sw_ff;
         end else if (paddr == `SBG_A_UNL) begin
            prdata_ff[0] <= ul_ff == sbg_pkg::UL_ARMED;
         end else if (paddr == `SBG_A_STAT) begin
            prdata_ff[9:0] <= {xtal_ff, fast_case_ff, st_ff, 1'b0, ul_ff};
         end else if (paddr == `SBG_A_VEC) begin
            prdata_ff[15:0] <= vec_ff;
         end else if (paddr >= `SBG_A_BLK && mapped(paddr)) begin
            prdata_ff[7:0] <= blk_ff[3'((paddr - `SBG_A_BLK) >> 2)];
         end
      end
   end

   assign prdata = prdata_ff;
   assign start_vector = vec_ff;
   assign cpu_hold = st_ff != sbg_pkg::ST_RUN;
   assign resume = resume_ff;
   assign resume_vector = resvec_ff;
   assign slow_switch_event = sw_evt_ff;
   assign clk_ctrl = '{slow_osc_en: slow_osc_ff, fast_osc_en: fast_osc_ff,
      slow_supply: slow_sup_ff, fast_supply: fast_sup_ff,
      slow_from_xtal: xtal_ff};

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_stop_wake;
      st_ff == sbg_pkg::ST_STOP && wake_stop ##1 st_ff == sbg_pkg::ST_WAKE;
   endsequence
   sequence s_halt_exit;
      st_ff == sbg_pkg::ST_HALT && wake_halt ##1 st_ff == sbg_pkg::ST_RUN;
   endsequence

   property p_halt_in;
      halt_go |=> st_ff == sbg_pkg::ST_HALT;
   endproperty
   a_halt_in: assert property (p_halt_in)
      else $error("halt not entered");
   property p_halt_out;
      st_ff == sbg_pkg::ST_HALT && wake_halt |-> s_halt_exit;
   endproperty
   a_halt_out: assert property (p_halt_out)
      else $error("halt not released");
   property p_halt_res;
      s_halt_exit |-> resume;
   endproperty
   a_halt_res: assert property (p_halt_res)
      else $error("no resume after halt");
   property p_refuse;
      wr_sby && pending && st_ff == sbg_pkg::ST_RUN |=>
         st_ff == sbg_pkg::ST_RUN;
   endproperty
   a_refuse: assert property (p_refuse)
      else $error("standby entered with pending request");
   property p_locked;
      wr_sby && pwdata[`SBG_B_STOP] && ul_ff != sbg_pkg::UL_ARMED |=>
         st_ff != sbg_pkg::ST_STOP;
   endproperty
   a_locked: assert property (p_locked)
      else $error("stop entered without unlock");
   property p_disarm;
      $rose(st_ff == sbg_pkg::ST_STOP) |-> ul_ff == sbg_pkg::UL_IDLE;
   endproperty
   a_disarm: assert property (p_disarm)
      else $error("unlock still armed in stop");
   property p_stop_off;
      st_ff == sbg_pkg::ST_STOP |-> clk_ctrl == '0;
   endproperty
   a_stop_off: assert property (p_stop_off)
      else $error("clock active in stop");
   property p_stop_hold;
      st_ff == sbg_pkg::ST_STOP && !wake_stop |=> st_ff == sbg_pkg::ST_STOP;
   endproperty
   a_stop_hold: assert property (p_stop_hold)
      else $error("stop left without wake source");
   property p_wake_osc;
      s_stop_wake |-> clk_ctrl.slow_osc_en && !clk_ctrl.slow_supply;
   endproperty
   a_wake_osc: assert property (p_wake_osc)
      else $error("slow oscillator not restarted");
   property p_switch;
      slow_switch_event |-> clk_ctrl.slow_from_xtal && !$past(xtal_ff);
   endproperty
   a_switch: assert property (p_switch)
      else $error("switch event without source change");
endmodule : sbg_standby
`default_nettype wire

// File: tb/sbg_osc_model.sv
`timescale 1ns/1ps
`default_nettype none
module sbg_osc_model (
   // Oscillator controls
   input wire sbg_pkg::sbg_clk_type clk_ctrl,
   // Oscillator outputs
   output logic rc_osc_pin,
   output logic fast_osc_pin,
   output logic slow_xtal_pin,
   output logic fast_osc_running
);
   initial begin
      rc_osc_pin = 1'b0;
      fast_osc_pin = 1'b0;
      slow_xtal_pin = 1'b0;
   end
   // Oscillators stand low while disabled
   always #37 rc_osc_pin = clk_ctrl.slow_osc_en & ~rc_osc_pin;
   always #17 slow_xtal_pin =
      clk_ctrl.slow_osc_en & ~slow_xtal_pin;
   always #13 fast_osc_pin =
      clk_ctrl.fast_osc_en & ~fast_osc_pin;
   assign fast_osc_running = clk_ctrl.fast_osc_en;
endmodule : sbg_osc_model
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sbg_consts.svh"
module tb_top;
   logic pclk, presetn, psel, penable, pwrite, cpu_on_fast, break_reset;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [1:0] break_exception_level_field;
   logic [63:0] irq_req, irq_en;
   sbg_pkg::sbg_core_type core;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, cpu_hold, resume, resume_vector;
   wire logic slow_switch_event, rc_osc_pin, fast_osc_pin, slow_xtal_pin;
   wire logic fast_osc_running;
   wire logic [15:0] start_vector;
   wire logic [39:0] blk_disable;
   wire sbg_pkg::sbg_clk_type clk_ctrl;
   int bad_count, cmp_count, n;
   logic [32:0] rdq[$], rvq[$];
   logic [39:0] bexp;
   logic [5:0] c;
   logic [31:0] v;
   logic [5:0] hc [6] = '{6'h06, 6'h03, 6'h11, 6'h20, 6'h2C, 6'h2B};

   sbg_standby #(.XTH_NS(100), .XTL_NS(100)) i_dut (.pclk, .presetn,
      .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
      .core, .irq_req, .irq_en, .cpu_on_fast, .break_reset, .break_exception_level_field,
      .start_vector, .cpu_hold, .resume, .resume_vector, .rc_osc_pin,
      .fast_osc_pin, .slow_xtal_pin, .fast_osc_running, .clk_ctrl,
      .slow_switch_event, .blk_disable);
   sbg_osc_model i_osc (.clk_ctrl, .rc_osc_pin, .fast_osc_pin,
      .slow_xtal_pin, .fast_osc_running);

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic chk(input logic [32:0] s, input logic [32:0] e);
      cmp_count++;
      if (s !== e) begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h exp %h", $time, s, e);
      end
   endtask : chk

   task automatic complete_run();
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : complete_run

   task automatic fail_to();
      bad_count++;
      complete_run();
   endtask : fail_to

   task automatic do_reset();
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
   endtask : do_reset

   task automatic apb(input logic [11:0] a, input logic w,
                      input logic [31:0] d);
      int k;
      k = 0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1'b1;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
         if (k > 100) fail_to();
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(a, 1'b1, d);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [32:0] e);
      rdq.push_back(e);
      apb(a, 1'b0, 32'h0);
   endtask : rd

   task automatic wait_res(output int k);
      k = 0;
      while (resume !== 1'b1) begin
         @(posedge pclk);
         k++;
         if (k > 40000) fail_to();
      end
   endtask : wait_res

   task automatic stop_seq();
      wr(`SBG_A_UNL, {24'h0, `SBG_UNL_1ST, 4'($urandom)});
      wr(`SBG_A_UNL, {24'h0, `SBG_UNL_2ND, 4'($urandom)});
      wr(`SBG_A_SBY, 32'h2);
   endtask : stop_seq

   always @(posedge pclk) begin
      if ((psel & penable & pready & ~pwrite) === 1'b1)
         chk({pslverr, prdata}, rdq.size() ? rdq.pop_front() : 33'hx);
      if (resume === 1'b1)
         chk({32'h0, resume_vector}, rvq.size() ? rvq.pop_front() : 33'hx);
   end

   initial begin
      {presetn, psel, penable, pwrite, cpu_on_fast, break_reset} = 6'h0;
      {paddr, pwdata, break_exception_level_field, irq_req, irq_en} = '0;
      core = '0;
      void'($urandom(32'h5efb));
      do_reset();
      n = 0;
      while (slow_switch_event !== 1'b1) begin
         @(posedge pclk);
         n++;
         if (n > 40000) fail_to();
      end
      chk(n >= 27000, 1);
      chk(clk_ctrl.slow_from_xtal, 1);
      $display("test xtal done");
      do_reset();
      chk(clk_ctrl, 5'h1E);
      chk({13'h0, blk_disable[39:20]}, 33'h0);
      chk({13'h0, blk_disable[19:0]}, 33'h0);
      rd(`SBG_A_SBY, {30'h0, `SBG_FOSC_RST, 2'h0});
      rd(`SBG_A_VEC, {17'h0, `SBG_VEC_NORM});
      rd(12'h030, {1'b1, 32'h0});
      for (int g = 0; g < `SBG_NGRP; g++) begin
         v = $urandom;
         bexp[8*g+:8] = v[7:0];
         wr(12'(`SBG_A_BLK + 4 * g), v);
         rd(12'(`SBG_A_BLK + 4 * g), {25'h0, v[7:0]});
      end
      chk({13'h0, blk_disable[39:20]}, {13'h0, bexp[39:20]});
      chk({13'h0, blk_disable[19:0]}, {13'h0, bexp[19:0]});
      $display("test regs done");
      irq_en[0] <= 1'b1;
      irq_req[0] <= 1'b1;
      wr(`SBG_A_SBY, 32'h1);
      chk(cpu_hold, 0);
      irq_req[0] <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         c = hc[i];
         core.master_irq_enable <= c[3];
         core.exception_level_field <= c[2:1];
         wr(`SBG_A_SBY, 32'h1);
         chk(cpu_hold, 1);
         rvq.push_back({32'h0, c[0]});
         core.nmi_req <= c[5:4] == 2'd0;
         core.wdt_req <= c[5:4] == 2'd1;
         irq_req[0] <= c[5];
         wait_res(n);
         chk(n, 2);
         {core.nmi_req, core.wdt_req, irq_req[0]} <= 3'h0;
         @(posedge pclk);
      end
      $display("test halt done");
      wr(`SBG_A_SBY, 32'h2);
      chk(cpu_hold, 0);
      wr(`SBG_A_UNL, 32'h50);
      wr(`SBG_A_UNL, 32'h30);
      wr(`SBG_A_UNL, 32'hA0);
      wr(`SBG_A_SBY, 32'h2);
      chk(cpu_hold, 0);
      wr(`SBG_A_SBY, 32'h4);
      stop_seq();
      chk(cpu_hold, 1);
      chk(clk_ctrl.slow_osc_en | clk_ctrl.fast_osc_en, 0);
      irq_req[0] <= 1'b1;
      irq_req[8] <= 1'b1;
      repeat (300) @(posedge pclk);
      chk(cpu_hold, 1);
      core.exception_level_field <= 2'd0;
      rvq.push_back(33'h1);
      irq_req[0] <= 1'b0;
      irq_en[8] <= 1'b1;
      wait_res(n);
      chk(n >= 900, 1);
      chk({clk_ctrl.fast_supply, clk_ctrl.slow_supply}, 3);
      {irq_req[8], irq_en[8]} <= 2'h0;
      @(posedge pclk);
      wr(`SBG_A_SBY, 32'h2);
      chk(cpu_hold, 0);
      cpu_on_fast <= 1'b1;
      core.exception_level_field <= 2'd3;
      stop_seq();
      chk(cpu_hold, 1);
      rvq.push_back(33'h0);
      core.nmi_req <= 1'b1;
      wait_res(n);
      chk(n >= 10000, 1);
      chk({clk_ctrl.fast_supply, clk_ctrl.slow_supply}, 3);
      core.nmi_req <= 1'b0;
      cpu_on_fast <= 1'b0;
      $display("test stop done");
      for (int i = 0; i < 4; i++) begin
         break_reset <= 1'b1;
         break_exception_level_field <= 2'(i);
         do_reset();
         rd(`SBG_A_VEC, i >= 2 ? 33'h2 : 33'h4);
         chk({17'h0, start_vector}, i >= 2 ? 33'h2 : 33'h4);
      end
      chk(rdq.size() + rvq.size(), 0);
      $display("test vector done");
      complete_run();
   end
endmodule : tb_top
`default_nettype wire
